// ---- hw/haptic_control_fifo_regs.sv ----
// control, status and queue-entry registers of the haptic driver core
// assumes a bus back end on i_mclk delivering byte reads and writes
`timescale 1ns/1ps
module haptic_control_fifo_regs #(
  parameter int MS_CYCLES     = haptic_pkg::MS_CYCLES,
  parameter int SAMPLE_CYCLES = haptic_pkg::SAMPLE_CYCLES,
  parameter logic [3:0] CHIP_ID = 4'h0 // arbitrary value
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rd_valid,
  output logic            o_boost_en,
  output logic            o_amp_en,
  output logic            o_source_select,
  output logic      [1:0] o_gain,
  output logic      [7:0] o_dac_data,
  output logic            o_dac_valid
);
  localparam int MW = $clog2(MS_CYCLES + 1);
  localparam int SW = $clog2(SAMPLE_CYCLES + 1);
  localparam int CW = $clog2(haptic_pkg::QUEUE_DEPTH + 1);

  generate
    if (MS_CYCLES < 1 || SAMPLE_CYCLES < 1) begin : g_bad_counts
      $error("divider counts must be at least one");
    end
  endgenerate

  logic          srst_reg;
  logic          standby_reg;
  logic [1:0]    timeout_reg;
  logic          override_reg;
  logic          source_reg;
  logic [1:0]    gain_reg;
  logic [7:0]    entry_reg;
  logic          awake_reg;
  logic [MW-1:0] ms_div_reg;
  logic [SW-1:0] smp_div_reg;
  logic [4:0]    idle_ms_reg;
  logic [4:0]    idle_limit;
  logic          ms_tick;
  logic          play_tick;
  logic          idle_done;
  logic          clear_all;
  logic          wr_ctrl;
  logic          push;
  logic          pop;
  logic          stages_next;
  logic [7:0]    q_data;
  logic          q_empty;
  logic          q_full;
  logic [CW-1:0] q_count;

  ////////////////////////////////////////////////////////////////////////
  // register writes
  assign wr_ctrl   = i_wr_en && (i_addr == haptic_pkg::CONTROL_OFFSET);
  assign clear_all = !i_rst_n || srst_reg;
  assign push      = i_wr_en && (i_addr == haptic_pkg::ENTRY_OFFSET);

  // one-cycle pulse in srst_reg, so the bit reads back zero except in that cycle
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= wr_ctrl && i_wdata[haptic_pkg::SOFT_RESET_BIT] && !srst_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      standby_reg  <= haptic_pkg::STANDBY_RESET;
      timeout_reg  <= haptic_pkg::TIMEOUT_RESET;
      override_reg <= haptic_pkg::OVERRIDE_RESET;
    end else if (wr_ctrl) begin
      standby_reg  <= i_wdata[haptic_pkg::STANDBY_BIT];
      timeout_reg  <= i_wdata[haptic_pkg::TIMEOUT_LSB +: 2];
      override_reg <= i_wdata[haptic_pkg::OVERRIDE_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      source_reg <= haptic_pkg::SOURCE_RESET;
      gain_reg   <= haptic_pkg::GAIN_RESET;
    end else if (i_wr_en && i_addr == haptic_pkg::SOURCE_OFFSET) begin
      source_reg <= i_wdata[haptic_pkg::SOURCE_BIT];
      gain_reg   <= i_wdata[haptic_pkg::GAIN_LSB +: 2];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      entry_reg <= haptic_pkg::ENTRY_RESET;
    end else if (push) begin
      entry_reg <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads, unmapped offsets answer zero
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata    <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      o_rdata    <= 8'h00;
      if (i_rd_en) begin
        case (i_addr)
          haptic_pkg::STATUS_OFFSET: begin
            o_rdata[haptic_pkg::EMPTY_BIT] <= q_empty;
            o_rdata[haptic_pkg::FULL_BIT]  <= q_full;
          end
          haptic_pkg::SOURCE_OFFSET: begin
            o_rdata[haptic_pkg::CHIP_ID_LSB +: 4]  <= CHIP_ID;
            o_rdata[haptic_pkg::SOURCE_BIT]        <= source_reg;
            o_rdata[haptic_pkg::GAIN_LSB +: 2]     <= gain_reg;
          end
          haptic_pkg::CONTROL_OFFSET: begin
            o_rdata[haptic_pkg::SOFT_RESET_BIT]  <= srst_reg;
            o_rdata[haptic_pkg::STANDBY_BIT]     <= standby_reg;
            o_rdata[haptic_pkg::TIMEOUT_LSB +: 2] <= timeout_reg;
            o_rdata[haptic_pkg::OVERRIDE_BIT]    <= override_reg;
          end
          haptic_pkg::ENTRY_OFFSET: begin
            o_rdata <= entry_reg;
          end
          default: begin
            o_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample queue; a soft reset flushes it
  sample_queue #(
    .WIDTH (haptic_pkg::SAMPLE_BITS),
    .DEPTH (haptic_pkg::QUEUE_DEPTH)
  ) u_queue (
    .i_mclk  (i_mclk),
    .i_clear (clear_all),
    .i_push  (push),
    .i_data  (i_wdata),
    .i_pop   (pop),
    .o_data  (q_data),
    .o_empty (q_empty),
    .o_full  (q_full),
    .o_count (q_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // dividers: millisecond tick and sample-rate tick
  assign ms_tick   = (ms_div_reg == MW'(MS_CYCLES - 1));
  assign play_tick = (smp_div_reg == SW'(SAMPLE_CYCLES - 1));

  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      ms_div_reg  <= '0;
      smp_div_reg <= '0;
    end else begin
      ms_div_reg  <= ms_tick ? '0 : ms_div_reg + 1'b1;
      smp_div_reg <= play_tick ? '0 : smp_div_reg + 1'b1;
    end
  end

  // digital samples play only while active and powered
  assign pop = play_tick && !q_empty && !standby_reg && !source_reg
               && o_amp_en;

  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      o_dac_data  <= 8'h00;
      o_dac_valid <= 1'b0;
    end else begin
      o_dac_valid <= pop;
      if (pop) begin
        o_dac_data <= q_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // idle timeout and power stages
  assign idle_limit = 5'(haptic_pkg::TIMEOUT_STEP_MS * (timeout_reg + 1));
  assign idle_done  = awake_reg && q_empty && ms_tick
                      && (idle_ms_reg + 1'b1 >= idle_limit);

  always_ff @(posedge i_mclk) begin
    if (clear_all || !q_empty || push || !awake_reg) begin
      idle_ms_reg <= '0;
    end else if (ms_tick) begin
      idle_ms_reg <= idle_ms_reg + 1'b1;
    end
  end

  // a new sample wakes the stages; the wake wins over a same-cycle idle
  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      awake_reg <= 1'b0;
    end else if (push) begin
      awake_reg <= 1'b1;
    end else if (idle_done) begin
      awake_reg <= 1'b0;
    end
  end

  // standby always gates the stages off, saving power over override
  assign stages_next = !standby_reg && (override_reg || awake_reg);

  always_ff @(posedge i_mclk) begin
    if (clear_all) begin
      o_boost_en <= 1'b0;
      o_amp_en   <= 1'b0;
    end else begin
      o_boost_en <= stages_next;
      o_amp_en   <= stages_next;
    end
  end

  assign o_source_select = source_reg;
  assign o_gain          = gain_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_soft_reset;
    wr_ctrl && i_wdata[haptic_pkg::SOFT_RESET_BIT] && !srst_reg;
  endsequence

  sequence s_defaults;
    standby_reg && timeout_reg == 2'h0 && !override_reg && q_empty;
  endsequence

  a_srst_defaults: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_soft_reset |=> srst_reg ##1 s_defaults)
    else $error("soft reset did not restore defaults");

  a_srst_reads_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    srst_reg |=> !srst_reg)
    else $error("soft reset bit stuck");

  a_standby_gates: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    standby_reg [*2] |-> !o_amp_en && !o_boost_en)
    else $error("power stages on in standby");

  a_timeout_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    idle_limit == ((timeout_reg == 2'h0) ? 5'h05 :
                   (timeout_reg == 2'h1) ? 5'h0a :
                   (timeout_reg == 2'h2) ? 5'h0f : 5'h14))
    else $error("wrong idle limit");

  a_idle_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    idle_done && !push && !override_reg && !wr_ctrl |=> ##1 !o_boost_en)
    else $error("stages stay on after idle timeout");

  a_override_on: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    override_reg && !standby_reg && !srst_reg |=> o_boost_en && o_amp_en)
    else $error("override did not hold stages on");

  a_entry_push: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    push && !q_full && !pop && !srst_reg |=> q_count == $past(q_count) + 1'b1)
    else $error("entry write not queued");

  a_full_refuse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    push && q_full && !pop && !srst_reg |=> q_full)
    else $error("full queue accepted a sample");

  a_empty_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_rd_en && i_addr == haptic_pkg::STATUS_OFFSET
    |=> o_rd_valid && o_rdata[1] == $past(q_empty))
    else $error("empty flag read wrong");

  a_analog_no_play: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    source_reg |=> !o_dac_valid)
    else $error("queue played with analog source");
endmodule // haptic_control_fifo_regs

// ---- pkg/haptic_pkg.sv ----
// constants shared by the haptic control register bank and its queue
// assumes a single 250 MHz core clock and a byte-wide register port
package haptic_pkg;
  // register offsets
  localparam logic [7:0] STATUS_OFFSET  = 8'h00;
  localparam logic [7:0] SOURCE_OFFSET  = 8'h01;
  localparam logic [7:0] CONTROL_OFFSET = 8'h02;
  localparam logic [7:0] ENTRY_OFFSET   = 8'h0b;
  // status field positions
  localparam int EMPTY_BIT = 1;
  localparam int FULL_BIT  = 0;
  // source register field positions
  localparam int CHIP_ID_LSB   = 3;
  localparam int SOURCE_BIT    = 2;
  localparam int GAIN_LSB      = 0;
  // control field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int STANDBY_BIT    = 6;
  localparam int TIMEOUT_LSB    = 2;
  localparam int OVERRIDE_BIT   = 1;
  // reset values
  localparam logic       STANDBY_RESET  = 1'b1;
  localparam logic [1:0] TIMEOUT_RESET  = 2'h0;
  localparam logic       OVERRIDE_RESET = 1'b0;
  localparam logic       SOURCE_RESET   = 1'b0;
  localparam logic [1:0] GAIN_RESET     = 2'h0;
  localparam logic [7:0] ENTRY_RESET    = 8'h00;
  // queue
  localparam int QUEUE_DEPTH = 100;
  localparam int SAMPLE_BITS = 8;
  // timing
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int MS_PERIOD_PS    = 1000000000;
  localparam int MS_CYCLES       = MS_PERIOD_PS / CLK_PERIOD_PS;
  localparam int TIMEOUT_STEP_MS = 5;
  localparam int SAMPLE_CYCLES   = 31250;
endpackage

// ---- hw/sample_queue.sv ----
// circular sample queue with flush, honest full and empty
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module sample_queue #(
  parameter int WIDTH = haptic_pkg::SAMPLE_BITS,
  parameter int DEPTH = haptic_pkg::QUEUE_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             i_mclk,
  input  wire logic             i_clear,
  input  wire logic             i_push,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_pop,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_empty,
  output logic                  o_full,
  output logic      [CW-1:0]    o_count
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2) begin : g_bad_depth
      $error("sample_queue depth must be at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             do_push;
  logic             do_pop;

  // push is dropped at full; nothing is overwritten
  assign do_push = i_push && (count_reg != CW'(DEPTH));
  assign do_pop  = i_pop && (count_reg != '0);
  assign o_data  = mem[rd_ptr_reg];
  assign o_empty = (count_reg == '0);
  assign o_full  = (count_reg == CW'(DEPTH));
  assign o_count = count_reg;

  always_ff @(posedge i_mclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sample_queue

// ---- verification/host_model.sv ----
// host side byte master of the haptic register bank
// assumes strobes are sampled on the rising edge of i_mclk
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] d);
    @(posedge i_mclk);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_mclk);
    o_rd_en <= 1'b0;
    o_addr  <= ~a;
    // answer stands for the cycle after the strobe edge
    @(posedge i_mclk);
    d = {i_rd_valid, i_rdata};
  endtask
endmodule // host_model

// ---- verification/testbench.sv ----
// self-checking bench of the haptic control registers and queue
// assumes shortened ms and sample periods set by parameter
`timescale 1ns/1ps
module testbench;
  localparam int MS = 10;
  logic       i_mclk, i_rst_n, wr_en, rd_en, rd_valid, boost_en, amp_en;
  logic       src, dac_valid;
  logic [7:0] addr, wdata, rdata, dac_data;
  logic [1:0] gain, g;
  logic [8:0] rb;
  int         fails, tests_run, cycles, seed, n, played, p0;
  int         q[$];
  haptic_control_fifo_regs #(.MS_CYCLES(MS), .SAMPLE_CYCLES(4)) i_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_boost_en(boost_en), .o_amp_en(amp_en), .o_source_select(src),
    .o_gain(gain), .o_dac_data(dac_data), .o_dac_valid(dac_valid));
  host_model i_host (
    .i_mclk(i_mclk), .i_rd_valid(rd_valid), .i_rdata(rdata),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_lvl(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, rb);
    tests_run++;
    if (rb !== {1'b1, exp}) begin
      fails++;
      $display("unexpected at %0t: read %h gave %h", $time, a, rb);
    end
  endtask
  // playback must follow the order the model accepted
  task automatic chk_dac(input logic [7:0] got);
    tests_run++;
    if (q.size() == 0 || got !== q[0]) begin
      fails++;
      $display("unexpected at %0t: sample %h", $time, got);
    end
    if (q.size() != 0) void'(q.pop_front());
  endtask
  // model queue mirrors what the device accepts
  task automatic put(input logic [7:0] d);
    i_host.wr(haptic_pkg::ENTRY_OFFSET, d);
    if (q.size() < 100) q.push_back(d);
  endtask
  task automatic drain();
    while (q.size() != 0) @(posedge i_mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  always @(posedge i_mclk) begin
    if (dac_valid === 1'b1) begin
      played++;
      chk_dac(dac_data);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_n = 1'b0;
    seed = 6840;
    cycles = 0;
    fails = 0;
    tests_run = 0;
    played = 0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk_rd(haptic_pkg::CONTROL_OFFSET, 8'h40);
    chk_rd(haptic_pkg::STATUS_OFFSET, 8'h02);
    chk_rd(haptic_pkg::ENTRY_OFFSET, 8'h00);
    chk_rd(8'h07, 8'h00);
    chk_lvl(boost_en, 1'b0, "stages on at reset");
    $display("done: defaults");
    for (int i = 0; i < 101; i++) put(8'($random(seed)));
    chk_rd(haptic_pkg::STATUS_OFFSET, 8'h01);
    i_host.wr(haptic_pkg::CONTROL_OFFSET, 8'h00);
    drain();
    chk_rd(haptic_pkg::STATUS_OFFSET, 8'h02);
    $display("done: fill and drain");
    // measure from the empty queue to the power stages dropping
    for (int s = 0; s < 4; s++) begin
      i_host.wr(haptic_pkg::CONTROL_OFFSET, 8'(s << 2));
      put(8'($random(seed)));
      drain();
      chk_lvl(amp_en, 1'b1, "amp off while waiting");
      n = 0;
      while (boost_en === 1'b1 && n < 400) begin
        @(posedge i_mclk);
        n++;
      end
      chk_lvl(n >= (5 * s + 4) * MS && n <= (5 * s + 6) * MS + 3, 1'b1,
              "idle delay");
    end
    $display("done: idle timeout");
    i_host.wr(haptic_pkg::CONTROL_OFFSET, 8'h02);
    put(8'h5a);
    drain();
    repeat (300) @(posedge i_mclk);
    chk_lvl(boost_en, 1'b1, "override boost");
    chk_lvl(amp_en, 1'b1, "override amp");
    i_host.wr(haptic_pkg::CONTROL_OFFSET, 8'h42);
    repeat (2) @(posedge i_mclk);
    chk_lvl(boost_en, 1'b0, "standby stages");
    $display("done: override");
    g = 2'($random(seed));
    i_host.wr(haptic_pkg::SOURCE_OFFSET, {5'h00, 1'b1, g});
    // the write lands at the edge the task returns on
    @(posedge i_mclk);
    chk_lvl(src, 1'b1, "analog source");
    chk_lvl(gain === g, 1'b1, "gain");
    i_host.wr(haptic_pkg::CONTROL_OFFSET, 8'h02);
    p0 = played;
    for (int i = 0; i < 3; i++) put(8'($random(seed)));
    repeat (40) @(posedge i_mclk);
    chk_lvl(played == p0, 1'b1, "queue played on analog");
    chk_rd(haptic_pkg::STATUS_OFFSET, 8'h00);
    $display("done: source select");
    i_host.wr(haptic_pkg::CONTROL_OFFSET, 8'h8e);
    q.delete();
    chk_rd(haptic_pkg::CONTROL_OFFSET, 8'h40);
    chk_rd(haptic_pkg::STATUS_OFFSET, 8'h02);
    chk_rd(haptic_pkg::SOURCE_OFFSET, 8'h00);
    chk_lvl(src, 1'b0, "source after soft reset");
    chk_lvl(boost_en, 1'b0, "stages after soft reset");
    $display("done: soft reset");
    end_of_test();
  end
endmodule // testbench
